// >>> bench/vdso_sink.sv
// downstream receiver model that takes words with the pixel strobe
`timescale 1ns/10ps
module vdso_sink (
   input  wire         pixel_strobe_clock,
   input  wire         digital_out_en,
   input  wire         regenerated_hsync_out,
   input  wire  [7:0]  red_sample_word,
   input  wire  [7:0]  green_sample_word,
   input  wire  [7:0]  blue_sample_word,
   output logic [23:0] last_word,
   output int          n_words,
   output int          n_hs
);
   initial begin
      last_word = 24'h0;
      n_words = 0;
      n_hs = 0;
   end
   // taken mid-word where the launch has settled; released pins are ignored
   always @(negedge pixel_strobe_clock) begin
      if (digital_out_en === 1'b1) begin
         last_word <= {red_sample_word, green_sample_word, blue_sample_word};
         n_words <= n_words + 1;
         if (regenerated_hsync_out === 1'b1) n_hs <= n_hs + 1;
      end
   end
endmodule // vdso_sink

// >>> bench/vdso_top_sva.sv
// assertion checker for the sync and pixel output block
`timescale 1ns/10ps
`include "vdso_regs.vh"
module vdso_chk (
   input wire       clk,
   input wire       rstn,
   input wire       register_reset_n,
   input wire       green_sync_input,
   input wire       cfg_load,
   input wire       cfg_out_hiz,
   input wire       regenerated_hsync_out,
   input wire       green_sync_slicer_out,
   input wire       pixel_strobe_clock,
   input wire [7:0] red_sample_word,
   input wire       digital_out_en,
   input wire [7:0] black_offset_red,
   input wire [6:0] slave_address
);
   // counts the launches that carry the regenerated hsync
   logic [4:0] hs_cnt;
   always @(posedge clk) begin
      if (!rstn)
         hs_cnt <= 5'h0;
      else if ($rose(pixel_strobe_clock))
         hs_cnt <= !regenerated_hsync_out ? 5'h0 :
                   $rose(regenerated_hsync_out) ? 5'h1 : hs_cnt + 5'h1;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   property p_stb_high;
      $rose(pixel_strobe_clock) |=> pixel_strobe_clock ##1 !pixel_strobe_clock;
   endproperty
   a_stb_high: assert property (p_stb_high) else $error("strobe high time wrong");
   property p_stb_low;
      $fell(pixel_strobe_clock) |=> !pixel_strobe_clock;
   endproperty
   a_stb_low: assert property (p_stb_low) else $error("strobe low time short");
   property p_word_hold;
      !$rose(pixel_strobe_clock) |-> $stable(red_sample_word);
   endproperty
   a_word_hold: assert property (p_word_hold) else $error("word moved off strobe");
   property p_hs_hold;
      !$rose(pixel_strobe_clock) |-> $stable(regenerated_hsync_out);
   endproperty
   a_hs_hold: assert property (p_hs_hold) else $error("hsync moved off strobe");
   property p_hs_width;
      $fell(regenerated_hsync_out) |-> hs_cnt == 5'h8;
   endproperty
   a_hs_width: assert property (p_hs_width) else $error("hsync width not eight");
   property p_en_off;
      cfg_load && register_reset_n && cfg_out_hiz |-> ##2 !digital_out_en;
   endproperty
   a_en_off: assert property (p_en_off) else $error("outputs not released");
   property p_en_on;
      cfg_load && register_reset_n && !cfg_out_hiz |-> ##2 digital_out_en;
   endproperty
   a_en_on: assert property (p_en_on) else $error("outputs not driven");
   property p_slice_hi;
      (green_sync_input) [*5] |-> green_sync_slicer_out;
   endproperty
   a_slice_hi: assert property (p_slice_hi) else $error("slicer out not high");
   property p_slice_lo;
      (!green_sync_input) [*5] |-> !green_sync_slicer_out;
   endproperty
   a_slice_lo: assert property (p_slice_lo) else $error("slicer out not low");
   property p_addr;
      $past(rstn) |-> slave_address[6:1] == `VDSO_SLAVE_BASE;
   endproperty
   a_addr: assert property (p_addr) else $error("slave address base wrong");
   property p_black_rst;
      (!register_reset_n) [*5] |-> black_offset_red == `VDSO_RST_OFFSET;
   endproperty
   a_black_rst: assert property (p_black_rst) else $error("offset not reset");
endmodule // vdso_chk

bind vdso_top vdso_chk u_chk (
   .clk(clk), .rstn(rstn), .register_reset_n(register_reset_n),
   .green_sync_input(green_sync_input), .cfg_load(cfg_load), .cfg_out_hiz(cfg_out_hiz),
   .regenerated_hsync_out(regenerated_hsync_out), .green_sync_slicer_out(green_sync_slicer_out),
   .pixel_strobe_clock(pixel_strobe_clock), .red_sample_word(red_sample_word),
   .digital_out_en(digital_out_en), .black_offset_red(black_offset_red),
   .slave_address(slave_address)
);

// >>> bench/video_digitizer_sync_output_tb.sv
// self-checking bench for the sync and pixel output block
`timescale 1ns/10ps
`include "vdso_regs.vh"
module video_digitizer_sync_output_tb;
   logic clk, rstn, register_reset_n, slave_address_select, hsync_in, vsync_in, coast_in;
   logic clamp_in, green_sync_input, adc_sample_clock, cfg_load, cfg_hsync_pol, pol;
   logic cfg_vsync_sep, cfg_ref_sog, cfg_coast_int, cfg_clamp_int, cfg_black_off;
   logic cfg_out_hiz, cfg_power_down;
   logic [9:0]  red_adc, green_adc, blue_adc, cfg_black_set;
   logic [3:0]  cfg_phase;
   wire         regenerated_hsync_out, vertical_sync_out, green_sync_slicer_out;
   wire         pixel_strobe_clock, digital_out_en, clamp_active, pll_coasting, sample_overrun;
   wire  [7:0]  red_sample_word, green_sample_word, blue_sample_word;
   wire  [7:0]  black_offset_red, black_offset_green, black_offset_blue;
   wire  [6:0]  slave_address;
   logic [23:0] last_word;
   logic [29:0] row_in [4];
   logic [23:0] row_out [4];
   int          n_words, n_hs, n_errors, n_checks, cyc, i, w0, h0;

   vdso_top dut (.clk, .rstn, .register_reset_n, .slave_address_select, .hsync_in, .vsync_in,
      .coast_in, .clamp_in, .green_sync_input, .adc_sample_clock, .red_adc, .green_adc,
      .blue_adc, .cfg_load, .cfg_hsync_pol, .cfg_vsync_sep, .cfg_ref_sog, .cfg_coast_int,
      .cfg_clamp_int, .cfg_black_off, .cfg_out_hiz, .cfg_power_down, .cfg_phase,
      .cfg_black_set, .regenerated_hsync_out, .vertical_sync_out, .green_sync_slicer_out,
      .pixel_strobe_clock, .red_sample_word, .green_sample_word, .blue_sample_word,
      .digital_out_en, .clamp_active, .pll_coasting, .black_offset_red, .black_offset_green,
      .black_offset_blue, .sample_overrun, .slave_address);
   vdso_sink u_sink (.pixel_strobe_clock, .digital_out_en, .regenerated_hsync_out,
      .red_sample_word, .green_sample_word, .blue_sample_word, .last_word, .n_words, .n_hs);

   always #25 clk = ~clk;

   task tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   task load;
      cfg_load = 1'b1;
      tick(1);
      cfg_load = 1'b0;
   endtask
   // one converter triple on the link, clocked out of phase with clk
   task sample(input logic [29:0] v);
      @(negedge clk);
      {red_adc, green_adc, blue_adc} = v;
      #207 adc_sample_clock = 1'b1;
      #200 adc_sample_clock = 1'b0;
   endtask
   task chk(input logic ok, input string msg);
      n_checks++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("CHECK FAILED %0t %s", $time, msg);
      end
   endtask
   task give_verdict;
      if (n_errors == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 12000) begin
         n_errors++;
         give_verdict();
      end
   end

   initial begin
      {clk, rstn, hsync_in, vsync_in, clamp_in, green_sync_input, adc_sample_clock} = '0;
      {cfg_load, cfg_hsync_pol, cfg_vsync_sep, cfg_ref_sog, cfg_coast_int, cfg_out_hiz} = '0;
      {register_reset_n, slave_address_select, cfg_clamp_int, cfg_black_off} = 4'he;
      coast_in = 1'b0;
      cfg_power_down = 1'b0;
      cfg_phase = 4'h0;
      cfg_black_set = `VDSO_RST_BLACK_SET;
      {red_adc, green_adc, blue_adc} = '0;
      {n_errors, n_checks, cyc} = '0;
      row_in = '{30'h00000bfe, 30'h20181bfb, 30'h0ffff155, 30'h3ff4000d};
      row_out = '{24'h0001ff, 24'h8082ff, 24'h40ff55, 24'hff4003};
      tick(3);
      rstn = 1'b1;
      tick(5);
      chk(slave_address === {`VDSO_SLAVE_BASE, 1'b1}, "address");
      for (i = 0; i < 4; i++) begin
         sample(row_in[i]);
         tick(8);
         chk(last_word === row_out[i], "sample word");
      end
      // leading edge of either polarity, trailing edge inside the burst
      pol = 1'b0;
      repeat (2) begin
         hsync_in = pol;
         cfg_hsync_pol = pol;
         load();
         tick(20);
         hsync_in = !pol;
         tick(40);
         hsync_in = pol;
         tick(960);
         w0 = n_words;
         h0 = n_hs;
         hsync_in = !pol;
         for (i = 0; i < 12; i++) begin
            if (i == 2) chk(clamp_active === 1'b1, "internal clamp");
            if (i == 5) begin
               tick(1);
               hsync_in = pol;
            end
            sample(30'h0ffff155);
         end
         tick(10);
         chk(n_words - w0 == 12, "word count");
         chk(n_hs - h0 == 8, "hsync launches");
         pol = ~pol;
      end
      coast_in = 1'b1;
      tick(10);
      chk(pll_coasting === 1'b1, "coast pin");
      hsync_in = 1'b0;
      tick(20);
      chk(clamp_active === 1'b0, "clamp during coast");
      hsync_in = 1'b1;
      coast_in = 1'b0;
      tick(10);
      chk(pll_coasting === 1'b0, "coast released");
      cfg_coast_int = 1'b1;
      load();
      vsync_in = 1'b1;
      tick(10);
      chk(pll_coasting === 1'b1, "internal coast");
      chk(vertical_sync_out === 1'b1, "vsync from pin");
      vsync_in = 1'b0;
      tick(10);
      chk(pll_coasting === 1'b1, "coast tail");
      tick(4000);
      chk(pll_coasting === 1'b0, "coast end");
      cfg_coast_int = 1'b0;
      cfg_vsync_sep = 1'b1;
      load();
      green_sync_input = 1'b1;
      tick(300);
      chk(vertical_sync_out === 1'b0, "separator early");
      tick(110);
      chk(vertical_sync_out === 1'b1, "separated vsync");
      green_sync_input = 1'b0;
      tick(6);
      chk(vertical_sync_out === 1'b0, "separator end");
      register_reset_n = 1'b0;
      tick(6);
      register_reset_n = 1'b1;
      {cfg_vsync_sep, cfg_hsync_pol, hsync_in} = 3'h0;
      tick(4);
      vsync_in = 1'b1;
      tick(6);
      chk(vertical_sync_out === 1'b1, "source back to pin");
      chk(black_offset_red === `VDSO_RST_OFFSET, "offset reset");
      vsync_in = 1'b0;
      cfg_out_hiz = 1'b1;
      load();
      tick(2);
      chk(digital_out_en === 1'b0, "outputs released");
      w0 = n_words;
      sample(row_in[1]);
      tick(8);
      chk(n_words == w0, "word while released");
      cfg_out_hiz = 1'b0;
      cfg_phase = 4'h3;
      load();
      tick(2);
      chk(digital_out_en === 1'b1, "outputs driven");
      sample(row_in[2]);
      tick(12);
      chk(last_word === row_out[2], "word after phase shift");
      cfg_clamp_int = 1'b0;
      load();
      clamp_in = 1'b1;
      tick(6);
      chk(clamp_active === 1'b1, "external clamp");
      tick(6);
      clamp_in = 1'b0;
      tick(6);
      chk(clamp_active === 1'b0, "external clamp off");
      slave_address_select = 1'b0;
      tick(5);
      chk(slave_address === {`VDSO_SLAVE_BASE, 1'b0}, "address pin");
      chk(sample_overrun === 1'b0, "no overrun");
      give_verdict();
   end
endmodule // video_digitizer_sync_output_tb

// >>> verilog/vdso_regs.vh
// constants for the video digitizer sync and pixel output logic
`ifndef VDSO_REGS_VH
`define VDSO_REGS_VH

// clock period and timing figures
`define VDSO_CLK_NS          50
`define VDSO_CLAMP_DLY_NS    500
`define VDSO_CLAMP_DLY_CYC   ((`VDSO_CLAMP_DLY_NS + `VDSO_CLK_NS - 1) / `VDSO_CLK_NS)
`define VDSO_CLAMP_W_NS      1000
`define VDSO_CLAMP_W_CYC     (`VDSO_CLAMP_W_NS / `VDSO_CLK_NS)
`define VDSO_VSEP_NS         20000
`define VDSO_VSEP_CYC        ((`VDSO_VSEP_NS + `VDSO_CLK_NS - 1) / `VDSO_CLK_NS)

// pixel strobe shape in clock cycles
`define VDSO_STB_HI          2'h2
`define VDSO_STB_LO          2'h2
// regenerated hsync width in strobes
`define VDSO_HS_STROBES      4'h8
// lines of coast after vertical sync ends
`define VDSO_COAST_LINES     4'h3

// pixel buffer
`define VDSO_FIFO_W          24
`define VDSO_FIFO_DEPTH      16
`define VDSO_FIFO_AW         4

// two-wire slave address upper bits, arbitrary value
`define VDSO_SLAVE_BASE      6'h26

// configuration reset values
`define VDSO_RST_HS_POL      1'h0
`define VDSO_RST_VS_SEP      1'h0
`define VDSO_RST_REF_SOG     1'h0
`define VDSO_RST_COAST_INT   1'h0
`define VDSO_RST_CLAMP_INT   1'h1
`define VDSO_RST_BLACK_OFF   1'h0
`define VDSO_RST_OUT_HIZ     1'h0
`define VDSO_RST_PHASE       4'h0
`define VDSO_RST_BLACK_SET   10'h040
`define VDSO_RST_OFFSET      8'h80

`endif

// >>> verilog/vdso_top.v
// video digitizer sync regeneration, clamp and coast timing, pixel output
`timescale 1ns/10ps
`include "vdso_regs.vh"

module vdso_fifo #(
   parameter WIDTH = 24,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             clk,
   input  wire             rstn,
   input  wire [WIDTH-1:0] in_data,
   input  wire             in_valid,
   output wire             in_ready,
   output wire [WIDTH-1:0] out_data,
   output wire             out_valid,
   input  wire             out_ready
);
   reg  [WIDTH-1:0] mem [0:DEPTH-1];
   reg  [AW:0]      wr_ptr;
   reg  [AW:0]      rd_ptr;
   wire             full;
   wire             empty;

   assign full      = (wr_ptr[AW] != rd_ptr[AW]) &&
                      (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   assign empty     = (wr_ptr == rd_ptr);
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = mem[rd_ptr[AW-1:0]];

   always @(posedge clk) begin
      if (in_valid && !full)
         mem[wr_ptr[AW-1:0]] <= in_data;
   end

   always @(posedge clk) begin
      if (!rstn) begin
         wr_ptr <= {(AW+1){1'b0}};
         rd_ptr <= {(AW+1){1'b0}};
      end else begin
         if (in_valid && !full)
            wr_ptr <= wr_ptr + 1'b1;
         if (out_ready && !empty)
            rd_ptr <= rd_ptr + 1'b1;
      end
   end
endmodule // vdso_fifo

module vdso_top (
   input  wire        clk,
   input  wire        rstn,
   input  wire        register_reset_n,
   input  wire        slave_address_select,
   input  wire        hsync_in,
   input  wire        vsync_in,
   input  wire        coast_in,
   input  wire        clamp_in,
   input  wire        green_sync_input,
   input  wire        adc_sample_clock,
   input  wire [9:0]  red_adc,
   input  wire [9:0]  green_adc,
   input  wire [9:0]  blue_adc,
   input  wire        cfg_load,
   input  wire        cfg_hsync_pol,
   input  wire        cfg_vsync_sep,
   input  wire        cfg_ref_sog,
   input  wire        cfg_coast_int,
   input  wire        cfg_clamp_int,
   input  wire        cfg_black_off,
   input  wire        cfg_out_hiz,
   input  wire        cfg_power_down,
   input  wire [3:0]  cfg_phase,
   input  wire [9:0]  cfg_black_set,
   output reg         regenerated_hsync_out,
   output reg         vertical_sync_out,
   output reg         green_sync_slicer_out,
   output reg         pixel_strobe_clock,
   output reg  [7:0]  red_sample_word,
   output reg  [7:0]  green_sample_word,
   output reg  [7:0]  blue_sample_word,
   output reg         digital_out_en,
   output reg         clamp_active,
   output reg         pll_coasting,
   output reg  [7:0]  black_offset_red,
   output reg  [7:0]  black_offset_green,
   output reg  [7:0]  black_offset_blue,
   output reg         sample_overrun,
   output reg  [6:0]  slave_address
);
   localparam [3:0]  S_IDLE  = 4'h1;
   localparam [3:0]  S_HIGH  = 4'h2;
   localparam [3:0]  S_LOW   = 4'h4;
   localparam [3:0]  S_SHIFT = 4'h8;
   localparam [15:0] CLP_DLY = `VDSO_CLAMP_DLY_CYC;
   localparam [15:0] CLP_END = `VDSO_CLAMP_DLY_CYC + `VDSO_CLAMP_W_CYC;
   localparam [15:0] VSEP    = `VDSO_VSEP_CYC;

   // ten-bit sample to eight-bit word, rounded and saturated
   function [7:0] reduce;
      input [9:0] s;
      begin
         if (s[9:2] == 8'hff)
            reduce = 8'hff;
         else
            reduce = s[9:2] + {7'h00, s[1]};
      end
   endfunction

   // one black loop step toward the black set level
   function [7:0] black_step;
      input [7:0] off;
      input [9:0] samp;
      input [9:0] set;
      begin
         if (samp > set && off != 8'h00)
            black_step = off - 8'h01;
         else if (samp < set && off != 8'hff)
            black_step = off + 8'h01;
         else
            black_step = off;
      end
   endfunction

   // pin synchronisers: hs, vs, coast, clamp, sog, adc clk, reg reset, addr
   reg  [7:0]  pin_s1;
   reg  [7:0]  pin_s2;
   reg  [29:0] dat_s1;
   reg  [29:0] dat_s2;
   reg         ck_d;
   wire        hs_s   = pin_s2[0];
   wire        vs_s   = pin_s2[1];
   wire        cst_s  = pin_s2[2];
   wire        clp_s  = pin_s2[3];
   wire        sog_s  = pin_s2[4];
   wire        ck_s   = pin_s2[5];
   wire        rrst_n = pin_s2[6];
   wire        a0_s   = pin_s2[7];

   always @(posedge clk) begin
      pin_s1 <= {slave_address_select, register_reset_n, adc_sample_clock,
                 green_sync_input, clamp_in, coast_in, vsync_in, hsync_in};
      pin_s2 <= pin_s1;
      dat_s1 <= {red_adc, green_adc, blue_adc};
      dat_s2 <= dat_s1;
      ck_d   <= ck_s;
   end

   // settings
   reg        c_hs_pol;
   reg        c_vs_sep;
   reg        c_ref_sog;
   reg        c_coast_int;
   reg        c_clamp_int;
   reg        c_black_off;
   reg        c_out_hiz;
   reg        c_pd;
   reg [3:0]  c_phase;
   reg [9:0]  c_black_set;

   always @(posedge clk) begin
      if (!rstn || !rrst_n) begin
         c_hs_pol    <= `VDSO_RST_HS_POL;
         c_vs_sep    <= `VDSO_RST_VS_SEP;
         c_ref_sog   <= `VDSO_RST_REF_SOG;
         c_coast_int <= `VDSO_RST_COAST_INT;
         c_clamp_int <= `VDSO_RST_CLAMP_INT;
         c_black_off <= `VDSO_RST_BLACK_OFF;
         c_out_hiz   <= `VDSO_RST_OUT_HIZ;
         c_pd        <= 1'b0;
         c_phase     <= `VDSO_RST_PHASE;
         c_black_set <= `VDSO_RST_BLACK_SET;
      end else if (cfg_load) begin // settings accepted in power-down too
         c_hs_pol    <= cfg_hsync_pol;
         c_vs_sep    <= cfg_vsync_sep;
         c_ref_sog   <= cfg_ref_sog;
         c_coast_int <= cfg_coast_int;
         c_clamp_int <= cfg_clamp_int;
         c_black_off <= cfg_black_off;
         c_out_hiz   <= cfg_out_hiz;
         c_pd        <= cfg_power_down;
         c_phase     <= cfg_phase;
         c_black_set <= cfg_black_set;
      end
   end

   // line reference and leading edge
   wire hs_act  = hs_s ^ c_hs_pol;
   wire ref_act = c_ref_sog ? sog_s : hs_act;
   reg  ref_d;
   wire lead    = ref_act && !ref_d;

   // vertical sync separator and coast generation
   reg  [15:0] sog_run;
   reg         sep_vs;
   reg  [3:0]  coast_lines;
   reg         int_coast;
   wire        vs_act = c_vs_sep ? sep_vs : vs_s;
   wire        coast  = c_coast_int ? int_coast : cst_s;

   // line timing flywheel
   reg  [15:0] per_cnt;
   reg  [15:0] lead_cnt;
   reg  [15:0] period;
   reg         line_start;
   reg  [15:0] clp_cnt;
   wire [15:0] per_nxt = per_cnt + 16'h0001;

   always @(posedge clk) begin
      if (!rstn) begin
         ref_d       <= 1'b0;
         per_cnt     <= 16'h0000;
         lead_cnt    <= 16'h0000;
         period      <= 16'h0000;
         line_start  <= 1'b0;
         sog_run     <= 16'h0000;
         sep_vs      <= 1'b0;
         coast_lines <= 4'h0;
         int_coast   <= 1'b0;
         clp_cnt     <= 16'hffff;
      end else begin
         ref_d      <= ref_act;
         line_start <= 1'b0;
         per_cnt    <= per_nxt;
         // line period is measured lead to lead, so flywheel starts do not shorten it
         if (lead)
            lead_cnt <= 16'h0000;
         else if (lead_cnt != 16'hffff)
            lead_cnt <= lead_cnt + 16'h0001;
         if (lead && !coast) begin
            period     <= lead_cnt + 16'h0001;
            per_cnt    <= 16'h0000;
            line_start <= 1'b1;
         end else if (period != 16'h0000 && per_nxt >= period) begin
            per_cnt    <= 16'h0000;
            line_start <= 1'b1;
         end
         if (!sog_s) begin
            sog_run <= 16'h0000;
            sep_vs  <= 1'b0;
         end else begin
            if (sog_run != 16'hffff)
               sog_run <= sog_run + 16'h0001;
            if (sog_run >= VSEP)
               sep_vs <= 1'b1;
         end
         if (vs_act)
            coast_lines <= `VDSO_COAST_LINES;
         else if (line_start && coast_lines != 4'h0)
            coast_lines <= coast_lines - 4'h1;
         int_coast <= vs_act || (coast_lines != 4'h0);
         if (line_start)
            clp_cnt <= 16'h0000;
         else if (clp_cnt != 16'hffff)
            clp_cnt <= clp_cnt + 16'h0001;
      end
   end

   wire int_clamp = (clp_cnt >= CLP_DLY) && (clp_cnt < CLP_END) &&
                    !coast;

   // sample capture into the pixel buffer
   wire        ck_edge  = ck_s && !ck_d;
   wire        in_ready;
   wire        push     = ck_edge && !c_pd;
   wire [23:0] in_word  = {reduce(dat_s2[29:20]), reduce(dat_s2[19:10]),
                           reduce(dat_s2[9:0])};
   wire [23:0] out_word;
   wire        out_valid;
   reg  [3:0]  state;
   reg  [3:0]  ph_last;
   wire        launch   = (state == S_IDLE) && !c_pd &&
                          (ph_last == c_phase) && out_valid;

   vdso_fifo #(
      .WIDTH (`VDSO_FIFO_W),
      .DEPTH (`VDSO_FIFO_DEPTH),
      .AW    (`VDSO_FIFO_AW)
   ) u_fifo (
      .clk       (clk),
      .rstn      (rstn),
      .in_data   (in_word),
      .in_valid  (push),
      .in_ready  (in_ready),
      .out_data  (out_word),
      .out_valid (out_valid),
      .out_ready (launch)
   );

   // strobe, data and hsync launch
   reg  [3:0] wait_cnt;
   reg        hs_pend;
   reg  [3:0] hs_left;

   always @(posedge clk) begin
      if (!rstn) begin
         state                 <= S_IDLE;
         ph_last               <= `VDSO_RST_PHASE;
         wait_cnt              <= 4'h0;
         hs_pend               <= 1'b0;
         hs_left               <= 4'h0;
         pixel_strobe_clock    <= 1'b0;
         regenerated_hsync_out <= 1'b0;
         red_sample_word       <= 8'h00;
         green_sample_word     <= 8'h00;
         blue_sample_word      <= 8'h00;
      end else begin
         if (line_start)
            hs_pend <= 1'b1;
         case (state)
            S_IDLE: begin
               if (!c_pd && ph_last != c_phase) begin
                  wait_cnt <= c_phase;
                  state    <= S_SHIFT;
               end else if (launch) begin
                  red_sample_word    <= out_word[23:16];
                  green_sample_word  <= out_word[15:8];
                  blue_sample_word   <= out_word[7:0];
                  pixel_strobe_clock <= 1'b1;
                  wait_cnt           <= {2'h0, `VDSO_STB_HI} - 4'h1;
                  state              <= S_HIGH;
                  if (hs_pend) begin
                     regenerated_hsync_out <= 1'b1;
                     hs_left               <= `VDSO_HS_STROBES - 4'h1;
                     if (!line_start)
                        hs_pend <= 1'b0;
                  end else if (hs_left != 4'h0) begin
                     hs_left <= hs_left - 4'h1;
                  end else begin
                     regenerated_hsync_out <= 1'b0;
                  end
               end
            end
            S_HIGH: begin
               if (wait_cnt == 4'h0) begin
                  pixel_strobe_clock <= 1'b0;
                  wait_cnt           <= {2'h0, `VDSO_STB_LO} - 4'h1;
                  state              <= S_LOW;
               end else begin
                  wait_cnt <= wait_cnt - 4'h1;
               end
            end
            S_LOW: begin
               if (wait_cnt == 4'h0)
                  state <= S_IDLE;
               else
                  wait_cnt <= wait_cnt - 4'h1;
            end
            S_SHIFT: begin
               if (wait_cnt == 4'h0) begin
                  ph_last <= c_phase;
                  state   <= S_IDLE;
               end else begin
                  wait_cnt <= wait_cnt - 4'h1;
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   // black loop, clamp, slicer, vertical sync and status outputs
   always @(posedge clk) begin
      if (!rstn || !rrst_n) begin
         black_offset_red   <= `VDSO_RST_OFFSET;
         black_offset_green <= `VDSO_RST_OFFSET;
         black_offset_blue  <= `VDSO_RST_OFFSET;
      end else if (ck_edge && clamp_active && !c_black_off) begin
         black_offset_red   <= black_step(black_offset_red, dat_s2[29:20], c_black_set);
         black_offset_green <= black_step(black_offset_green, dat_s2[19:10], c_black_set);
         black_offset_blue  <= black_step(black_offset_blue, dat_s2[9:0], c_black_set);
      end
   end

   always @(posedge clk) begin
      if (!rstn) begin
         vertical_sync_out     <= 1'b0;
         green_sync_slicer_out <= 1'b0;
         digital_out_en        <= 1'b0;
         clamp_active          <= 1'b0;
         pll_coasting          <= 1'b0;
         sample_overrun        <= 1'b0;
         slave_address         <= 7'h00;
      end else begin
         vertical_sync_out     <= vs_act;
         green_sync_slicer_out <= sog_s;
         digital_out_en        <= !c_out_hiz;
         clamp_active          <= c_clamp_int ? int_clamp : clp_s;
         pll_coasting          <= coast;
         slave_address         <= {`VDSO_SLAVE_BASE, a0_s};
         if (push && !in_ready)
            sample_overrun <= 1'b1;
      end
   end
endmodule // vdso_top
